// *** hdl/fls_pin_sync.sv ***
/*
 * Two-flop synchroniser for every asynchronous pin and analog
 * comparator level that the register bank looks at.
 * Assumes raw inputs may change at any time relative to clk_sys_in.
 */
module fls_pin_sync
	import fls_pkg::*;
#(
	parameter int WIDTH = FLS_SYNC_WIDTH
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] raw_in,
	fls_sync_if.src sync_out
);

	logic [WIDTH-1:0] stage_one;
	logic [WIDTH-1:0] stage_two;

	// -------------------------------------------------------------
	// Synchroniser chain
	// -------------------------------------------------------------
	// First stage feeds only the second stage
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			stage_one <= '0;
			stage_two <= '0;
		end else begin
			stage_one <= raw_in;
			stage_two <= stage_one;
		end
	end

	assign sync_out.level = stage_two;

endmodule

// *** hdl/fls_pkg.sv ***
/*
 * Package of the flash LED status and configuration register bank:
 * register addresses, reset values, field positions and pin-sync indices.
 * Assumes a host-side two-wire front end that turns bus transfers into
 * single-cycle register strobes on the same clock.
 */
package fls_pkg;

	// -------------------------------------------------------------
	// Register addresses
	// -------------------------------------------------------------
	localparam logic [7:0] FLS_ADDR_FLAGS = 8'h0B;
	localparam logic [7:0] FLS_ADDR_CFG1 = 8'h0C;
	localparam logic [7:0] FLS_ADDR_CFG2 = 8'h0D;
	localparam logic [7:0] FLS_ADDR_GPIO = 8'h0E;
	localparam logic [7:0] FLS_UNMAPPED_READ = 8'h00;

	// -------------------------------------------------------------
	// Reset values and fixed read-back bits
	// -------------------------------------------------------------
	localparam logic [7:0] FLS_CFG1_RESET = 8'h42;
	localparam logic [7:0] FLS_CFG1_WMASK = 8'hEF;
	localparam logic [3:0] FLS_CFG2_RESET = 4'h0;
	localparam logic [3:0] FLS_CFG2_FILL = 4'hF;
	localparam logic [6:0] FLS_GPIO_RESET = 7'h00;
	localparam logic [6:0] FLS_FLAGS_RESET = 7'h00;

	// -------------------------------------------------------------
	// Flag bit positions in the status register
	// -------------------------------------------------------------
	localparam int FLS_FL_TIMEOUT = 0;
	localparam int FLS_FL_DIE_HOT = 1;
	localparam int FLS_FL_LED_FAIL = 2;
	localparam int FLS_FL_SYNC_ONE = 3;
	localparam int FLS_FL_SYNC_TWO = 4;
	localparam int FLS_FL_THERM = 5;
	localparam int FLS_FL_UNUSED = 6;
	localparam int FLS_FL_SUPPLY = 7;

	// -------------------------------------------------------------
	// First configuration register fields
	// -------------------------------------------------------------
	localparam int FLS_C1_LIGHT_LOAD_OFF = 0;
	localparam int FLS_C1_LEVEL_5V = 1;
	localparam int FLS_C1_TRIG_INHIBIT = 2;
	localparam int FLS_C1_THERM_MODE = 3;
	localparam int FLS_C1_PIN2_SYNC = 5;
	localparam int FLS_C1_INHIBIT_HIGH = 6;
	localparam int FLS_C1_HW_TORCH = 7;

	// -------------------------------------------------------------
	// Second configuration register fields
	// -------------------------------------------------------------
	localparam int FLS_C2_SYNC_TWO_OFF = 0;
	localparam int FLS_C2_THERM_OFF = 1;
	localparam int FLS_C2_ALT_TORCH = 2;
	localparam int FLS_C2_SUPPLY_OFF = 3;

	// -------------------------------------------------------------
	// General-purpose pin register fields
	// -------------------------------------------------------------
	localparam int FLS_G_P1_GPIO = 0;
	localparam int FLS_G_P1_OUT = 1;
	localparam int FLS_G_P1_DATA = 2;
	localparam int FLS_G_P2_GPIO = 3;
	localparam int FLS_G_P2_OUT = 4;
	localparam int FLS_G_P2_DATA = 5;
	localparam int FLS_G_THERM_IRQ = 6;

	// -------------------------------------------------------------
	// Index of each asynchronous input in the synchronised vector
	// -------------------------------------------------------------
	localparam int FLS_SYNC_WIDTH = 8;
	localparam int FLS_S_PIN1 = 0;
	localparam int FLS_S_PIN2 = 1;
	localparam int FLS_S_TRIG = 2;
	localparam int FLS_S_THERM_LOW = 3;
	localparam int FLS_S_SUPPLY_LOW = 4;
	localparam int FLS_S_LED_FAIL = 5;
	localparam int FLS_S_DIE_HOT = 6;
	localparam int FLS_S_TIMEOUT = 7;

endpackage

// *** hdl/fls_regs.sv ***
/*
 * Status and configuration register bank of a camera-flash LED driver:
 * fault/event flags, pin-role and output configuration, fault response
 * configuration and general-purpose pin control.
 * Assumes a two-wire bus front end on clk_sys_in giving one-cycle
 * read and write strobes, and analog blocks supplying comparator levels.
 */
// Function
// - Eight-bit flags, unused bit one, reset zero
// - Supply flag needs monitor enabled and low
// - LED fail, die hot, timeout flags
// - Thermistor and sync-pin change flags, mode-gated
// - Config bit 7 picks pin one role
// - Config bit 6 sets inhibit polarity
// - Config bit 5 picks pin two role
// - Config bit 3 picks thermistor pin role
// - Config bit 2 blocks flash trigger output, not alternate torch
// - Config bit 1 picks 4.5 or 5 volts
// - Config bit 0 disables light-load comparator
// - Second config bits choose torch or off
// - Alternate torch: pin one before trigger
// - Both multi-function pins usable as GPIO
// - GPIO bit 6 mirrors thermistor flag out
module fls_regs
	import fls_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Register port from the two-wire front end
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// Multi-function pins, three signals each
	input wire logic multi_function_pin_one_in,
	output logic multi_function_pin_one_out,
	output logic multi_function_pin_one_oe_n_out,
	input wire logic multi_function_pin_two_in,
	output logic multi_function_pin_two_out,
	output logic multi_function_pin_two_oe_n_out,
	// Trigger pin and analog status levels
	input wire logic flash_trigger_in,
	input wire logic thermistor_below_trip_in,
	input wire logic supply_input_below_in,
	input wire logic supply_monitor_enable_in,
	input wire logic led_fail_in,
	input wire logic die_over_temp_in,
	input wire logic flash_timeout_in,
	// Controls toward the converter
	output logic hw_torch_enable_out,
	output logic flash_inhibit_out,
	output logic force_voltage_mode_out,
	output logic thermistor_compare_mode_out,
	output logic indicator_current_enable_out,
	output logic flash_trigger_out,
	output logic output_level_select_out,
	output logic light_load_disable_out,
	output logic force_torch_out,
	output logic leds_off_out,
	output logic alternate_torch_no_timeout_out
);

	// -------------------------------------------------------------
	// Storage and synchronised inputs
	// -------------------------------------------------------------
	logic [6:0] flags;
	logic [7:0] cfg1;
	logic [3:0] cfg2;
	logic [6:0] gpio;
	logic [FLS_SYNC_WIDTH-1:0] lvl;
	logic [FLS_SYNC_WIDTH-1:0] lvl_prev;
	logic [FLS_SYNC_WIDTH-1:0] raw;
	logic [7:0] flags_view;
	logic [6:0] flag_set;
	logic flag_clear;
	logic pin1_sync_mode;
	logic pin2_sync_mode;
	logic pin2_volt_mode;
	logic therm_mode;
	logic therm_trip;
	logic supply_fault;
	logic sync_two_event;
	logic trig_rise;
	logic alt_torch;
	logic next_force_torch;
	logic next_leds_off;

	fls_sync_if sync_bus ();

	// Gather raw asynchronous levels into one vector
	always_comb begin
		raw = '0;
		raw[FLS_S_PIN1] = multi_function_pin_one_in;
		raw[FLS_S_PIN2] = multi_function_pin_two_in;
		raw[FLS_S_TRIG] = flash_trigger_in;
		raw[FLS_S_THERM_LOW] = thermistor_below_trip_in;
		raw[FLS_S_SUPPLY_LOW] = supply_input_below_in;
		raw[FLS_S_LED_FAIL] = led_fail_in;
		raw[FLS_S_DIE_HOT] = die_over_temp_in;
		raw[FLS_S_TIMEOUT] = flash_timeout_in;
	end

	fls_pin_sync #(
		.WIDTH(FLS_SYNC_WIDTH)
	) u_sync (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.raw_in(raw),
		.sync_out(sync_bus.src)
	);

	assign lvl = sync_bus.level;

	// Previous synchronised levels for edge detection
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			lvl_prev <= '0;
		end else begin
			lvl_prev <= lvl;
		end
	end

	// -------------------------------------------------------------
	// Pin roles
	// -------------------------------------------------------------
	// Role of each pin when not taken over as GPIO
	always_comb begin
		pin1_sync_mode = !gpio[FLS_G_P1_GPIO] &&
			!cfg1[FLS_C1_HW_TORCH];
		pin2_sync_mode = !gpio[FLS_G_P2_GPIO] &&
			cfg1[FLS_C1_PIN2_SYNC];
		pin2_volt_mode = !gpio[FLS_G_P2_GPIO] &&
			!cfg1[FLS_C1_PIN2_SYNC];
		therm_mode = cfg1[FLS_C1_THERM_MODE];
	end

	// Fault conditions as levels, plus the trigger rising edge
	always_comb begin
		therm_trip = therm_mode && lvl[FLS_S_THERM_LOW];
		supply_fault = supply_monitor_enable_in &&
			lvl[FLS_S_SUPPLY_LOW];
		sync_two_event = pin2_sync_mode && lvl[FLS_S_PIN2];
		trig_rise = lvl[FLS_S_TRIG] && !lvl_prev[FLS_S_TRIG];
	end

	// -------------------------------------------------------------
	// Flags register
	// -------------------------------------------------------------
	// Set conditions for each sticky flag
	always_comb begin
		flag_set = '0;
		flag_set[FLS_FL_TIMEOUT] = lvl[FLS_S_TIMEOUT];
		flag_set[FLS_FL_DIE_HOT] = lvl[FLS_S_DIE_HOT];
		flag_set[FLS_FL_LED_FAIL] = lvl[FLS_S_LED_FAIL];
		flag_set[FLS_FL_SYNC_ONE] = pin1_sync_mode &&
			(lvl[FLS_S_PIN1] != lvl_prev[FLS_S_PIN1]);
		flag_set[FLS_FL_SYNC_TWO] = pin2_sync_mode &&
			(lvl[FLS_S_PIN2] != lvl_prev[FLS_S_PIN2]);
		flag_set[FLS_FL_THERM] = therm_trip;
		flag_set[FLS_FL_UNUSED] = 1'b0;
		flag_set[FLS_FL_SUPPLY - 1] = supply_fault;
	end

	assign flag_clear = reg_read_in && (reg_addr_in == FLS_ADDR_FLAGS);

	// Sticky flags, cleared by a read, a new event wins
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			flags <= FLS_FLAGS_RESET;
		end else if (flag_clear) begin
			flags <= flag_set;
		end else begin
			flags <= flags | flag_set;
		end
	end

	// Stored 7 bits mapped onto the 8-bit view, unused bit reads one
	assign flags_view = {flags[FLS_FL_SUPPLY - 1], 1'b1,
		flags[FLS_FL_THERM:0]};

	// -------------------------------------------------------------
	// Configuration and GPIO registers
	// -------------------------------------------------------------
	// First configuration register, bit 4 fixed at zero
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cfg1 <= FLS_CFG1_RESET;
		end else if (reg_write_in && reg_addr_in == FLS_ADDR_CFG1) begin
			cfg1 <= reg_wdata_in & FLS_CFG1_WMASK;
		end
	end

	// Second configuration register, upper nibble not stored
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cfg2 <= FLS_CFG2_RESET;
		end else if (reg_write_in && reg_addr_in == FLS_ADDR_CFG2) begin
			cfg2 <= reg_wdata_in[3:0];
		end
	end

	// General-purpose pin register, bit 7 not stored
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			gpio <= FLS_GPIO_RESET;
		end else if (reg_write_in && reg_addr_in == FLS_ADDR_GPIO) begin
			gpio <= reg_wdata_in[6:0];
		end
	end

	// Read data, one cycle after the read strobe
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			reg_rdata_out <= FLS_UNMAPPED_READ;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_read_in;
			if (reg_read_in) begin
				case (reg_addr_in)
					FLS_ADDR_FLAGS: reg_rdata_out <= flags_view;
					FLS_ADDR_CFG1: reg_rdata_out <= cfg1;
					FLS_ADDR_CFG2: reg_rdata_out <= {FLS_CFG2_FILL, cfg2};
					FLS_ADDR_GPIO: begin
						// Input pins read back their level
						reg_rdata_out <= {1'b1, gpio[FLS_G_THERM_IRQ],
							gpio[FLS_G_P2_OUT] ? gpio[FLS_G_P2_DATA] :
							lvl[FLS_S_PIN2],
							gpio[FLS_G_P2_OUT:FLS_G_P2_GPIO],
							gpio[FLS_G_P1_OUT] ? gpio[FLS_G_P1_DATA] :
							lvl[FLS_S_PIN1],
							gpio[FLS_G_P1_OUT:FLS_G_P1_GPIO]};
					end
					default: reg_rdata_out <= FLS_UNMAPPED_READ;
				endcase
			end
		end
	end

	// -------------------------------------------------------------
	// Alternate external torch
	// -------------------------------------------------------------
	// Pin one high at trigger rise holds torch until trigger falls
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			alt_torch <= 1'b0;
		end else if (!lvl[FLS_S_TRIG] || !pin1_sync_mode ||
			!cfg2[FLS_C2_ALT_TORCH]) begin
			alt_torch <= 1'b0;
		end else if (trig_rise && lvl[FLS_S_PIN1]) begin
			alt_torch <= 1'b1;
		end
	end

	// -------------------------------------------------------------
	// Fault responses
	// -------------------------------------------------------------
	// Each fault goes to torch or off as its config bit says
	always_comb begin
		next_force_torch = 1'b0;
		next_leds_off = 1'b0;
		if (supply_fault) begin
			if (cfg2[FLS_C2_SUPPLY_OFF]) begin
				next_leds_off = 1'b1;
			end else begin
				next_force_torch = 1'b1;
			end
		end
		if (therm_trip) begin
			if (cfg2[FLS_C2_THERM_OFF]) begin
				next_leds_off = 1'b1;
			end else begin
				next_force_torch = 1'b1;
			end
		end
		if (sync_two_event) begin
			if (cfg2[FLS_C2_SYNC_TWO_OFF]) begin
				next_leds_off = 1'b1;
			end else begin
				next_force_torch = 1'b1;
			end
		end
		if (pin1_sync_mode && lvl[FLS_S_PIN1] &&
			!cfg2[FLS_C2_ALT_TORCH]) begin
			next_force_torch = 1'b1;
		end
	end

	// -------------------------------------------------------------
	// Registered converter controls
	// -------------------------------------------------------------
	// All converter controls leave through flip-flops
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			hw_torch_enable_out <= 1'b0;
			flash_inhibit_out <= 1'b0;
			force_voltage_mode_out <= 1'b0;
			thermistor_compare_mode_out <= 1'b0;
			indicator_current_enable_out <= 1'b1;
			flash_trigger_out <= 1'b0;
			output_level_select_out <= 1'b1;
			light_load_disable_out <= 1'b0;
			force_torch_out <= 1'b0;
			leds_off_out <= 1'b0;
			alternate_torch_no_timeout_out <= 1'b0;
		end else begin
			hw_torch_enable_out <= !gpio[FLS_G_P1_GPIO] &&
				cfg1[FLS_C1_HW_TORCH] && lvl[FLS_S_PIN1];
			flash_inhibit_out <= pin2_sync_mode &&
				(lvl[FLS_S_PIN2] == cfg1[FLS_C1_INHIBIT_HIGH]);
			force_voltage_mode_out <= pin2_volt_mode &&
				lvl[FLS_S_PIN2];
			thermistor_compare_mode_out <= therm_mode;
			indicator_current_enable_out <= !therm_mode;
			flash_trigger_out <= lvl[FLS_S_TRIG] &&
				!cfg1[FLS_C1_TRIG_INHIBIT];
			output_level_select_out <= cfg1[FLS_C1_LEVEL_5V];
			light_load_disable_out <= cfg1[FLS_C1_LIGHT_LOAD_OFF];
			force_torch_out <= next_force_torch || alt_torch;
			leds_off_out <= next_leds_off;
			alternate_torch_no_timeout_out <= alt_torch;
		end
	end

	// -------------------------------------------------------------
	// Multi-function pin drivers
	// -------------------------------------------------------------
	// Pin one drives only as a GPIO output
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			multi_function_pin_one_out <= 1'b0;
			multi_function_pin_one_oe_n_out <= 1'b1;
		end else begin
			multi_function_pin_one_out <= gpio[FLS_G_P1_DATA];
			multi_function_pin_one_oe_n_out <= !(gpio[FLS_G_P1_GPIO] &&
				gpio[FLS_G_P1_OUT]);
		end
	end

	// Pin two: GPIO data, or open-drain low on thermistor flag
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			multi_function_pin_two_out <= 1'b0;
			multi_function_pin_two_oe_n_out <= 1'b1;
		end else if (gpio[FLS_G_P2_GPIO] && gpio[FLS_G_P2_OUT]) begin
			if (gpio[FLS_G_THERM_IRQ]) begin
				multi_function_pin_two_out <= 1'b0;
				multi_function_pin_two_oe_n_out <=
					!flags[FLS_FL_THERM];
			end else begin
				multi_function_pin_two_out <= gpio[FLS_G_P2_DATA];
				multi_function_pin_two_oe_n_out <= 1'b0;
			end
		end else begin
			multi_function_pin_two_out <= 1'b0;
			multi_function_pin_two_oe_n_out <= 1'b1;
		end
	end

endmodule

// *** hdl/fls_sync_if.sv ***
/*
 * Carrier for the synchronised input levels between the pin
 * synchroniser and the register bank. Assumes one clock domain.
 */
interface fls_sync_if;
	import fls_pkg::*;

	logic [FLS_SYNC_WIDTH-1:0] level;

	// Synchroniser drives, register bank reads
	modport src (output level);
	modport dst (input level);
endinterface

// *** tb/fls_far_model.sv ***
/*
 * Far-side model of the two multi-function pins: external levels
 * change just after a clock edge, and the device drive wins on the
 * wire while its active-low enable is low.
 */
module fls_far_model (
	input wire logic clk_sys_in,
	input wire logic pin_one_level_in,
	input wire logic pin_two_level_in,
	input wire logic pin_one_drive_in,
	input wire logic pin_one_oe_n_in,
	input wire logic pin_two_drive_in,
	input wire logic pin_two_oe_n_in,
	output logic pin_one_out,
	output logic pin_two_out
);
	logic one_far;
	logic two_far;

	// External drivers update after the edge
	always_ff @(posedge clk_sys_in) begin
		one_far <= pin_one_level_in;
		two_far <= pin_two_level_in;
	end

	// Wire level seen by the device
	assign pin_one_out = pin_one_oe_n_in ? one_far : pin_one_drive_in;
	assign pin_two_out = pin_two_oe_n_in ? two_far : pin_two_drive_in;
endmodule

// *** tb/fls_regs_checker.sv ***
/*
 * Concurrent checks on the ports of the flash LED register bank.
 * Assumes one clock domain, synchronous active-high reset and the
 * three-cycle pin-to-output latency of the two-flop input path.
 */
module fls_regs_checker
	import fls_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic reg_rvalid_out,
	input wire logic multi_function_pin_one_in,
	input wire logic flash_trigger_in,
	input wire logic hw_torch_enable_out,
	input wire logic flash_inhibit_out,
	input wire logic force_voltage_mode_out,
	input wire logic thermistor_compare_mode_out,
	input wire logic indicator_current_enable_out,
	input wire logic flash_trigger_out,
	input wire logic output_level_select_out,
	input wire logic light_load_disable_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	// -------------------------------------------------------------
	// Register port timing
	// -------------------------------------------------------------
	read_valid_a: assert property (reg_read_in |=> reg_rvalid_out)
		else $error("read strobe not answered");
	valid_cause_a: assert property (reg_rvalid_out |-> $past(reg_read_in))
		else $error("read valid without a read");
	rdata_hold_a: assert property (!$past(reg_read_in) |-> $stable(reg_rdata_out))
		else $error("read data moved without a read");
	unused_one_a: assert property (reg_read_in &&
		reg_addr_in == FLS_ADDR_FLAGS |=> reg_rdata_out[FLS_FL_UNUSED])
		else $error("unused status bit read as zero");

	// -------------------------------------------------------------
	// Configuration outputs
	// -------------------------------------------------------------
	level_select_a: assert property (reg_write_in &&
		reg_addr_in == FLS_ADDR_CFG1 && reg_wdata_in[1]
		|-> ##[1:2] output_level_select_out)
		else $error("output level not at 5 V after write");
	light_load_a: assert property (reg_write_in &&
		reg_addr_in == FLS_ADDR_CFG1 && !reg_wdata_in[0]
		|-> ##[1:2] !light_load_disable_out)
		else $error("light-load comparator left disabled");
	therm_pair_a: assert property (indicator_current_enable_out
		!= thermistor_compare_mode_out)
		else $error("indicator current on in comparator mode");
	trig_gate_a: assert property (flash_trigger_out
		|-> $past(flash_trigger_in, 3))
		else $error("trigger passed without a trigger input");
	torch_pin_a: assert property (hw_torch_enable_out
		|-> $past(multi_function_pin_one_in, 3))
		else $error("hardware torch without pin one high");
	pin_two_role_a: assert property (flash_inhibit_out
		|-> !force_voltage_mode_out)
		else $error("pin two in both roles at once");
endmodule

bind fls_regs fls_regs_checker u_chk (.*);

// *** tb/tb.sv ***
/*
 * Self-checking bench of the flash LED register bank: register
 * reset values, writes, flag events and pin roles.
 * Assumes the register strobe contract and 100 MHz clock.
 */
module tb
	import fls_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_sys_in = 0, rst_in = 1, reg_write_in = 0, reg_read_in = 0;
	logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
	logic flash_trigger_in = 0, thermistor_below_trip_in = 0;
	logic supply_input_below_in = 0, supply_monitor_enable_in = 0;
	logic led_fail_in = 0, die_over_temp_in = 0, flash_timeout_in = 0;
	logic lvl_one = 0, lvl_two = 0, reg_rvalid_out;
	logic multi_function_pin_one_in, multi_function_pin_one_out;
	logic multi_function_pin_one_oe_n_out, multi_function_pin_two_in;
	logic multi_function_pin_two_out, multi_function_pin_two_oe_n_out;
	logic hw_torch_enable_out, flash_inhibit_out, force_voltage_mode_out;
	logic thermistor_compare_mode_out, indicator_current_enable_out;
	logic flash_trigger_out, output_level_select_out, light_load_disable_out;
	logic force_torch_out, leds_off_out, alternate_torch_no_timeout_out;
	logic [15:0] exp_q[$];
	logic [7:0] d;
	int fails = 0, n_checks = 0, cycles = 0;

	always #5 clk_sys_in = ~clk_sys_in;

	fls_regs u_dut (.*);
	fls_far_model u_far (.clk_sys_in, .pin_one_level_in(lvl_one),
		.pin_two_level_in(lvl_two),
		.pin_one_drive_in(multi_function_pin_one_out),
		.pin_one_oe_n_in(multi_function_pin_one_oe_n_out),
		.pin_two_drive_in(multi_function_pin_two_out),
		.pin_two_oe_n_in(multi_function_pin_two_oe_n_out),
		.pin_one_out(multi_function_pin_one_in),
		.pin_two_out(multi_function_pin_two_in));

	// -------------------------------------------------------------
	// Shared tasks
	// -------------------------------------------------------------
	task automatic finish_test();
		// A read note never answered counts as a mismatch
		if (exp_q.size() != 0) fails++;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys_in);
		reg_write_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= v;
		@(posedge clk_sys_in);
		reg_write_in <= 1'b0;
	endtask

	// Read strobe; expected data noted for the watcher
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys_in);
		reg_read_in <= 1'b1;
		reg_addr_in <= a;
		exp_q.push_back({a, e});
		@(posedge clk_sys_in);
		reg_read_in <= 1'b0;
	endtask

	task automatic chk(input string nm, input logic seen, input logic e);
		n_checks++;
		if (seen !== e) begin
			fails++;
			$display("unexpected %s: expected %b seen %b", nm, e, seen);
		end
	endtask

	// Watcher: each read answer against the oldest note
	always @(posedge clk_sys_in) begin
		if (reg_rvalid_out === 1'b1) begin
			n_checks++;
			if (exp_q.size() == 0) begin
				fails++;
				$display("unexpected read: expected none seen %h", reg_rdata_out);
			end else if (reg_rdata_out !== exp_q[0][7:0]) begin
				fails++;
				$display("unexpected reg %h: expected %h seen %h",
					exp_q[0][15:8], exp_q[0][7:0], reg_rdata_out);
			end
			if (exp_q.size() != 0) void'(exp_q.pop_front());
		end
	end

	// Hang guard
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			finish_test();
		end
	end

	// -------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------
	initial begin
		void'($urandom(32'h22133211));
		cyc(16);
		rst_in <= 1'b0;
		// Reset values, refused writes, unmapped place
		rd(FLS_ADDR_FLAGS, 8'h40);
		rd(FLS_ADDR_CFG1, 8'h42);
		rd(FLS_ADDR_CFG2, 8'hF0);
		rd(FLS_ADDR_GPIO, 8'h80);
		chk("level select", output_level_select_out, 1'b1);
		chk("indicator", indicator_current_enable_out, 1'b1);
		wr(FLS_ADDR_FLAGS, 8'hFF);
		wr(8'h3F, 8'hFF);
		rd(FLS_ADDR_FLAGS, 8'h40);
		rd(8'h3F, 8'h00);
		$display("reset test done");
		// Random configuration writes
		repeat (4) begin
			d = 8'($urandom);
			wr(FLS_ADDR_CFG1, d);
			wr(FLS_ADDR_CFG2, d);
			rd(FLS_ADDR_CFG1, d & 8'hEF);
			rd(FLS_ADDR_CFG2, {4'hF, d[3:0]});
			chk("level select", output_level_select_out, d[1]);
			chk("light load", light_load_disable_out, d[0]);
			chk("therm mode", thermistor_compare_mode_out, d[3]);
		end
		wr(FLS_ADDR_CFG1, 8'h42);
		wr(FLS_ADDR_CFG2, 8'h00);
		$display("config test done");
		// Level faults, supply monitor gated by its enable
		{led_fail_in, die_over_temp_in, flash_timeout_in} <= 3'b111;
		supply_input_below_in <= 1'b1;
		cyc(6);
		chk("force torch", force_torch_out, 1'b0);
		{led_fail_in, die_over_temp_in, flash_timeout_in} <= 3'b000;
		supply_input_below_in <= 1'b0;
		cyc(6);
		rd(FLS_ADDR_FLAGS, 8'h47);
		rd(FLS_ADDR_FLAGS, 8'h40);
		supply_monitor_enable_in <= 1'b1;
		supply_input_below_in <= 1'b1;
		cyc(6);
		chk("force torch", force_torch_out, 1'b1);
		wr(FLS_ADDR_CFG2, 8'h08);
		cyc(3);
		chk("leds off", leds_off_out, 1'b1);
		chk("force torch", force_torch_out, 1'b0);
		supply_input_below_in <= 1'b0;
		cyc(6);
		supply_monitor_enable_in <= 1'b0;
		rd(FLS_ADDR_FLAGS, 8'hC0);
		$display("fault test done");
		// Pin events in the default roles
		{lvl_one, lvl_two, thermistor_below_trip_in} <= 3'b111;
		cyc(6);
		chk("voltage mode", force_voltage_mode_out, 1'b1);
		chk("hw torch", hw_torch_enable_out, 1'b0);
		chk("force torch", force_torch_out, 1'b1);
		{lvl_one, lvl_two, thermistor_below_trip_in} <= 3'b000;
		cyc(6);
		rd(FLS_ADDR_FLAGS, 8'h48);
		// Torch, sync and comparator roles
		wr(FLS_ADDR_CFG1, 8'hE8);
		{lvl_one, lvl_two, thermistor_below_trip_in} <= 3'b111;
		cyc(6);
		chk("hw torch", hw_torch_enable_out, 1'b1);
		chk("inhibit", flash_inhibit_out, 1'b1);
		chk("voltage mode", force_voltage_mode_out, 1'b0);
		chk("force torch", force_torch_out, 1'b1);
		chk("leds off", leds_off_out, 1'b0);
		rd(FLS_ADDR_FLAGS, 8'h70);
		wr(FLS_ADDR_CFG1, 8'hA8);
		cyc(3);
		chk("inhibit", flash_inhibit_out, 1'b0);
		{lvl_one, lvl_two} <= 2'b00;
		cyc(6);
		rd(FLS_ADDR_FLAGS, 8'h70);
		// Pin two pulls low while the thermistor flag is set
		wr(FLS_ADDR_GPIO, 8'h58);
		cyc(4);
		chk("pin two oe_n", multi_function_pin_two_oe_n_out, 1'b0);
		chk("pin two out", multi_function_pin_two_out, 1'b0);
		thermistor_below_trip_in <= 1'b0;
		cyc(6);
		rd(FLS_ADDR_FLAGS, 8'h60);
		cyc(3);
		chk("pin two oe_n", multi_function_pin_two_oe_n_out, 1'b1);
		wr(FLS_ADDR_GPIO, 8'h07);
		cyc(3);
		chk("pin one oe_n", multi_function_pin_one_oe_n_out, 1'b0);
		chk("pin one out", multi_function_pin_one_out, 1'b1);
		rd(FLS_ADDR_GPIO, 8'h87);
		wr(FLS_ADDR_GPIO, 8'h00);
		$display("pin test done");
		// Trigger passes only while enabled; alternate torch latches
		wr(FLS_ADDR_CFG1, 8'h42);
		wr(FLS_ADDR_CFG2, 8'h04);
		lvl_one <= 1'b1;
		cyc(6);
		chk("force torch", force_torch_out, 1'b0);
		chk("alt torch", alternate_torch_no_timeout_out, 1'b0);
		flash_trigger_in <= 1'b1;
		cyc(6);
		chk("trigger", flash_trigger_out, 1'b1);
		chk("alt torch", alternate_torch_no_timeout_out, 1'b1);
		chk("force torch", force_torch_out, 1'b1);
		wr(FLS_ADDR_CFG1, 8'h46);
		cyc(3);
		chk("trigger", flash_trigger_out, 1'b0);
		{flash_trigger_in, lvl_one} <= 2'b00;
		cyc(6);
		chk("alt torch", alternate_torch_no_timeout_out, 1'b0);
		$display("trigger test done");
		finish_test();
	end
endmodule
